// [verilog/asfc_pkg.sv]
// What this block does
// - set done flag bit 7 each sequence end
// - clear done: write one, start, fast-read
// - edge mode: trigger during sequence sets overrun
// - clear trigger overrun: one, control, start
// - result write with done flag sets overrun
// - clear result overrun: one, control, start
// - read-only 4-bit index in bits 3..0
// - non-queue: index zero at start and end
// - index wraps after maximum count
// - abort or start clears index always
// - status always accessible; index not writable
// - per-conversion done flag set at conversion end
// - start write aborts then starts sequence
package asfc_pkg;
    // ****************************************
    // register map, byte addresses = index * 4
    // ****************************************
    localparam logic [3:0] ASFC_IDX_STATUS = 4'h6;
    localparam logic [3:0] ASFC_IDX_CTRL = 4'h0;
    localparam logic [3:0] ASFC_IDX_IRQ_STAT = 4'h1;
    localparam logic [3:0] ASFC_IDX_IRQ_EN = 4'h2;
    localparam logic [3:0] ASFC_IDX_IRQ_CLR = 4'h3;
    localparam logic [3:0] ASFC_IDX_DONE_FLAGS = 4'h4;
    // ****************************************
    // field positions
    // ****************************************
    localparam int ASFC_BIT_DONE = 7;
    localparam int ASFC_BIT_TRIG_OVR = 5;
    localparam int ASFC_BIT_RES_OVR = 4;
    localparam int ASFC_BIT_FAST_CLR = 0;
    localparam int ASFC_BIT_QUEUE = 1;
    localparam int ASFC_BIT_TRIG_LEVEL = 2;
    localparam int ASFC_NUM_CONV = 12;
    localparam int ASFC_NUM_IRQ = 3;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] ASFC_CTRL_RESET = 3'h0;
    localparam logic [3:0] ASFC_INDEX_RESET = 4'h0;
endpackage

// [verilog/asfc_index_counter.sv]
`timescale 1ns/1ns
// conversion index counter, wraps at its maximum
module asfc_index_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic advance,
    output logic [3:0] index
);
    logic [3:0] index_reg;
    logic [3:0] index_next;

    // next index: clear has priority over advance
    always_comb begin
        index_next = index_reg;
        if (clear) begin
            index_next = 4'h0;
        end else if (advance) begin
            index_next = index_reg + 4'h1;
        end
    end

    // index register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_reg <= asfc_pkg::ASFC_INDEX_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    assign index = index_reg;
endmodule

// [verilog/asfc_status.sv]
`timescale 1ns/1ns
// status flags and conversion counter of the converter sequencer
module asfc_status (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter events, one-cycle pulses on pclk, except scan_mode, which is a level
    input wire logic seq_start_write,
    input wire logic ctrl_abort_write,
    input wire logic seq_end,
    input wire logic scan_mode,
    input wire logic conv_done,
    input wire logic trigger_edge,
    input wire logic result_write,
    input wire logic result_read,
    // status outputs
    output logic seq_active,
    output logic [3:0] conversion_index,
    output logic [11:0] conversion_done_flags,
    output logic irq
);
    // ****************************************
    // bus decode
    // ****************************************
    logic acc;
    logic wr;
    logic [3:0] idx;
    logic hit;
    logic wr_status;
    logic wr_ctrl;
    logic wr_ien;
    logic wr_iclr;

    assign idx = paddr[5:2];
    assign acc = psel && penable;
    // writes to unmapped addresses are dropped
    assign wr = acc && pwrite && pstrb[0] && hit;
    assign wr_status = wr && (idx == asfc_pkg::ASFC_IDX_STATUS);
    assign wr_ctrl = wr && (idx == asfc_pkg::ASFC_IDX_CTRL);
    assign wr_ien = wr && (idx == asfc_pkg::ASFC_IDX_IRQ_EN);
    assign wr_iclr = wr && (idx == asfc_pkg::ASFC_IDX_IRQ_CLR);
    assign hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
        (idx == asfc_pkg::ASFC_IDX_STATUS ||
         idx == asfc_pkg::ASFC_IDX_CTRL ||
         idx == asfc_pkg::ASFC_IDX_IRQ_STAT ||
         idx == asfc_pkg::ASFC_IDX_IRQ_EN ||
         idx == asfc_pkg::ASFC_IDX_IRQ_CLR ||
         idx == asfc_pkg::ASFC_IDX_DONE_FLAGS);
    // zero wait states
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    // ****************************************
    // state registers
    // ****************************************
    logic done_reg;
    logic done_next;
    logic tovr_reg;
    logic tovr_next;
    logic rovr_reg;
    logic rovr_next;
    logic active_reg;
    logic active_next;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic [2:0] ist_reg;
    logic [2:0] ist_next;
    logic [2:0] ien_reg;
    logic [2:0] ien_next;
    logic [11:0] cdf_reg;
    logic [11:0] cdf_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic restart;
    logic abort;
    logic fast_clr;
    logic queue_mode;
    logic cnt_clear;
    logic cnt_adv;
    logic [3:0] index;
    logic cur_flag;
    logic ev_tovr;
    logic ev_rovr;
    logic [2:0] events;
    logic [7:0] status_view;

    assign restart = seq_start_write;
    assign abort = ctrl_abort_write || seq_start_write;
    assign fast_clr = ctrl_reg[asfc_pkg::ASFC_BIT_FAST_CLR];
    assign queue_mode = ctrl_reg[asfc_pkg::ASFC_BIT_QUEUE];
    assign cur_flag = (index < 4'hC) ? cdf_reg[index] : 1'b0;
    assign ev_tovr = trigger_edge && active_reg &&
        !ctrl_reg[asfc_pkg::ASFC_BIT_TRIG_LEVEL];
    assign ev_rovr = result_write && cur_flag;
    assign events = {ev_rovr, ev_tovr, seq_end};

    assign cnt_clear = abort || (!queue_mode && seq_end);
    assign cnt_adv = conv_done;

    // conversion index counter
    asfc_index_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .clear(cnt_clear),
        .advance(cnt_adv),
        .index(index)
    );

    assign status_view = {done_reg, 1'h0, tovr_reg, rovr_reg, index};

    // ****************************************
    // sequencer activity
    // ****************************************
    // next activity: a start wins over abort and end
    always_comb begin
        active_next = active_reg;
        if (restart) begin
            // a start always leaves the sequencer running
            active_next = 1'h1;
        end else if (ctrl_abort_write) begin
            // control writes stop the sequence
            active_next = 1'h0;
        end else if (seq_end && !scan_mode) begin
            // single sequence stops, scan goes on
            active_next = 1'h0;
        end
    end

    // activity register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= 1'h0;
        end else begin
            active_reg <= active_next;
        end
    end

    // ****************************************
    // sequence and overrun flags
    // ****************************************
    // next flags: a set wins over a clear in one cycle
    always_comb begin
        // done clears; set wins over clear
        done_next = done_reg;
        if ((wr_status && pwdata[asfc_pkg::ASFC_BIT_DONE]) || restart ||
            (fast_clr && result_read)) begin
            done_next = 1'h0;
        end
        // done set at every sequence end
        if (seq_end) begin
            done_next = 1'h1;
        end
        tovr_next = tovr_reg;
        if ((wr_status && pwdata[asfc_pkg::ASFC_BIT_TRIG_OVR]) || abort) begin
            tovr_next = 1'h0;
        end
        // late trigger edge sets it
        if (ev_tovr) begin
            tovr_next = 1'h1;
        end
        rovr_next = rovr_reg;
        if ((wr_status && pwdata[asfc_pkg::ASFC_BIT_RES_OVR]) || abort) begin
            rovr_next = 1'h0;
        end
        // overwrite of unread result sets it
        if (ev_rovr) begin
            rovr_next = 1'h1;
        end
    end

    // flag registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'h0;
            tovr_reg <= 1'h0;
            rovr_reg <= 1'h0;
        end else begin
            done_reg <= done_next;
            tovr_reg <= tovr_next;
            rovr_reg <= rovr_next;
        end
    end

    // ****************************************
    // per-conversion done flags
    // ****************************************
    // one flag per result register
    generate
        for (genvar i = 0; i < asfc_pkg::ASFC_NUM_CONV; i++) begin : g_flag
            logic here; // flag of the current conversion
            assign here = (index == 4'(i));
            // start clear wins over set, set wins over read clear
            assign cdf_next[i] = restart ? 1'h0 :
                (conv_done && here) ? 1'h1 :
                (fast_clr && result_read && here) ? 1'h0 : cdf_reg[i];
        end
    endgenerate

    // per-conversion flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdf_reg <= 12'h000;
        end else begin
            cdf_reg <= cdf_next;
        end
    end

    // ****************************************
    // control and interrupt registers
    // ****************************************
    // next control, enables and sticky events
    always_comb begin
        // control bits take a written word
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata[2:0];
        end
        // interrupt enables take a written word
        ien_next = ien_reg;
        if (wr_ien) begin
            ien_next = pwdata[2:0];
        end
        // write-one clear first, so a new event wins
        ist_next = ist_reg;
        if (wr_iclr) begin
            ist_next = ist_reg & ~pwdata[2:0];
        end
        ist_next = ist_next | events;
    end

    // control and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= asfc_pkg::ASFC_CTRL_RESET;
            ien_reg <= 3'h0;
            ist_reg <= 3'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            ien_reg <= ien_next;
            ist_reg <= ist_next;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // read mux, captured in setup for the access phase
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            // unmapped addresses read as zero
            prdata_next = 32'h0;
            if (hit) begin
                case (idx)
                    asfc_pkg::ASFC_IDX_STATUS: begin
                        prdata_next = {24'h0, status_view};
                    end
                    asfc_pkg::ASFC_IDX_CTRL: begin
                        prdata_next = {29'h0, ctrl_reg};
                    end
                    asfc_pkg::ASFC_IDX_IRQ_STAT: begin
                        prdata_next = {29'h0, ist_reg};
                    end
                    asfc_pkg::ASFC_IDX_IRQ_EN: begin
                        prdata_next = {29'h0, ien_reg};
                    end
                    asfc_pkg::ASFC_IDX_DONE_FLAGS: begin
                        prdata_next = {20'h0, cdf_reg};
                    end
                    // write-only clear register reads zero
                    default: begin
                        prdata_next = 32'h0;
                    end
                endcase
            end
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = prdata_reg;
    assign seq_active = active_reg;
    assign conversion_index = index;
    assign conversion_done_flags = cdf_reg;
    // level interrupt while an enabled event is pending
    assign irq = |(ist_reg & ien_reg);
endmodule

// [tb/asfc_status_sva.sv]
`timescale 1ns/1ns
// ****
// status checker
// ****
module asfc_status_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic seq_start_write,
    input wire logic ctrl_abort_write,
    input wire logic seq_end,
    input wire logic conv_done,
    input wire logic seq_active,
    input wire logic [3:0] conversion_index,
    input wire logic [11:0] conversion_done_flags
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // start or abort
    wire logic clr = seq_start_write || ctrl_abort_write;
    // plain conversion step
    wire logic step = conv_done && seq_active && !clr && !seq_end;
    // status read access
    wire logic rd = psel && penable && !pwrite && paddr == 12'h018;
    idx_clear_a: assert property (
        clr |=> conversion_index == 4'h0) else $error("index kept");
    idx_step_a: assert property (
        step |=> conversion_index == $past(conversion_index) + 4'h1)
        else $error("index did not advance");
    idx_hold_a: assert property (
        !conv_done && !clr && !seq_end |=> $stable(conversion_index))
        else $error("index changed");
    flag_set_a: assert property (
        step && conversion_index < 4'hC
        |=> conversion_done_flags[$past(conversion_index)])
        else $error("done flag not set");
    flag_clr_a: assert property (
        seq_start_write |=> conversion_done_flags == 12'h000)
        else $error("done flags kept");
    seq_run_a: assert property (
        seq_start_write |=> seq_active) else $error("not active");
    rd_index_a: assert property (
        rd |-> prdata[3:0] == $past(conversion_index))
        else $error("read index wrong");
    rd_gap_a: assert property (
        rd |-> prdata[6] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("unused bits set");
endmodule
bind asfc_status asfc_status_chk u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .seq_start_write, .ctrl_abort_write, .seq_end, .conv_done,
    .seq_active, .conversion_index, .conversion_done_flags
);

// [tb/tb_asfc_status.sv]
`timescale 1ns/1ns
module tb_asfc_status;
    // ****
    // bench state
    // ****
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic scan = 0; // continuous scan level
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] ev = 7'h00; // event pulses
    logic [31:0] prdata;
    logic pready, pslverr, seq_active, irq;
    logic [3:0] conversion_index;
    logic [11:0] conversion_done_flags;
    logic [32:0] q[$]; // expected error flag and read data
    logic [32:0] note; // oldest note taken by the monitor
    logic [7:0] r = 8'h61; // lfsr state
    int mismatches = 0, checks = 0, n;
    localparam logic [11:0] ST = 12'h018, CT = 12'h000;
    localparam logic [11:0] IE = 12'h008, IC = 12'h00C;
    localparam logic [11:0] DF = 12'h010, NA = 12'h01C;
    asfc_status dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr,
        .seq_start_write(ev[0]), .ctrl_abort_write(ev[1]),
        .seq_end(ev[2]), .scan_mode(scan), .conv_done(ev[3]),
        .trigger_edge(ev[4]), .result_write(ev[5]),
        .result_read(ev[6]), .seq_active, .conversion_index,
        .conversion_done_flags, .irq
    );
    // 4 ns clock
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ****
    // tasks
    // ****
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input string s, input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer, bounded wait on pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready) break;
        end
        psel <= 0;
        penable <= 0;
        if (i == 20) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back({a == NA, e});
        apb(0, a, 32'h0);
    endtask
    // one-cycle event pulse
    task automatic pulse(input logic [6:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 7'h00;
    endtask
    // read monitor takes oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready && q.size() > 0) begin
            note = q.pop_front();
            chk("pslverr", pslverr, note[32]);
            chk("prdata", prdata, note[31:0]);
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rd(ST, 32'h0);
        r = lfsr(r);
        n = 1 + r[2:0];
        pulse(7'h01);
        repeat (n) pulse(7'h08);
        rd(ST, n);
        rd(DF, (32'h1 << n) - 32'h1);
        apb(1, IE, 32'h1);
        pulse(7'h04);
        #1 chk("irq", irq, 32'h1);
        rd(ST, 32'h80);
        apb(1, IC, 32'h1);
        #1 chk("irq", irq, 32'h0);
        apb(1, ST, 32'hFF);
        rd(ST, 32'h0);
        pulse(7'h01);
        pulse(7'h08);
        pulse(7'h10);
        rd(ST, 32'h21);
        apb(1, ST, 32'h4F);
        rd(ST, 32'h21);
        pulse(7'h02);
        pulse(7'h20);
        rd(ST, 32'h10);
        apb(1, ST, 32'h10);
        rd(ST, 32'h0);
        apb(1, CT, 32'h2);
        pulse(7'h01);
        repeat (3) pulse(7'h08);
        pulse(7'h04);
        rd(ST, 32'h83);
        pulse(7'h01);
        repeat (17) pulse(7'h08);
        rd(ST, 32'h01);
        apb(1, CT, 32'h1);
        pulse(7'h01);
        pulse(7'h04);
        pulse(7'h40);
        rd(ST, 32'h0);
        rd(NA, 32'h0);
        scan <= 1;
        apb(1, CT, 32'h4);
        pulse(7'h01);
        pulse(7'h10);
        pulse(7'h04);
        #1 chk("active", seq_active, 32'h1);
        rd(ST, 32'h80);
        apb(1, ST, 32'h80);
        pulse(7'h04);
        rd(ST, 32'h80);
        end_of_test();
    end
endmodule
